/* File: logic/atr_pkg.sv */
package atr_pkg;
  localparam logic [7:0] ADDR_TURNS = 8'h2c;
  localparam logic [7:0] ADDR_FILT = 8'h30;
  localparam logic [7:0] ADDR_FINE = 8'h32;
  localparam logic [7:0] ADDR_CROSS = 8'h34;
  localparam logic [7:0] ADDR_KEY = 8'h3c;
  localparam logic [2:0] TURNS_ID = 3'h6;
  localparam int PAR_POS = 12;
  localparam int EF_POS = 14;
  localparam int UV_POS = 13;
  localparam int UNL_POS = 0;
  localparam int CODE_LSB = 8;
  localparam int KEY_STEPS = 5;
  localparam logic [7:0] KEY_C0 = 8'h00;
  localparam logic [7:0] KEY_C1 = 8'h27;
  localparam logic [7:0] KEY_C2 = 8'h81;
  localparam logic [7:0] KEY_C3 = 8'h1f;
  localparam logic [7:0] KEY_C4 = 8'h77;
  localparam logic [11:0] TURNS_MAX_180 = 12'h1ff;
  localparam logic [11:0] TURNS_MIN_180 = 12'he00;
  localparam logic [11:0] TURNS_MAX_45 = 12'h7ff;
  localparam logic [11:0] TURNS_MIN_45 = 12'h800;
  localparam logic [11:0] TURNS_RST = 12'h000;
  localparam logic [2:0] STEP_RST = 3'h0;

  typedef struct packed {
    logic [11:0] turns;
    logic overflow;
    logic [2:0] step;
    logic unlocked;
    logic [15:0] rdata;
  } atr_state_type;
endpackage : atr_pkg

/* File: logic/atr_regs.sv */
`timescale 1ns/100ps
// How it works
// - turns word top bits read 110
// - turns word parity bit makes odd ones
// - turns field signed count since reset or turns reset
// - step 180 or 45 sets count span
// - tracks 512 rotations either step size
// - error flag is OR of unmasked faults
// - undervoltage is masked OR of detectors
// - filtered and crossing words parity gives odd ones, fine word has no parity
// - filtered angle 12-bit, bit15 zero
// - fine angle 15-bit, bit15 zero
// - crossing angle from zero-crossing path
// - unlock after five correct code writes
// - protected writes only while unlocked
// - key bit0 unlocked, bits 15:1 zero
// - overflow warning latched until turns reset
module atr_regs (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire logic [15:0] WDATA,
  output logic [15:0] RDATA,
  input wire logic TURN_UP,
  input wire logic TURN_DN,
  input wire logic TURNS_RESET,
  input wire logic STEP_45,
  input wire logic [11:0] FILT_ANGLE,
  input wire logic [14:0] FINE_ANGLE,
  input wire logic [11:0] CROSS_ANGLE,
  input wire logic ANY_FAULT,
  input wire logic UV_ANALOG,
  input wire logic UV_DIGITAL,
  input wire logic MASK_UVA,
  input wire logic MASK_UVD,
  input wire logic PROT_REQ,
  output logic PROT_GRANT,
  output logic PROT_REFUSE,
  output logic UNLOCKED,
  output logic OVERFLOW_WARN
);
  atr_pkg::atr_state_type st_ff, nxt_st;
  logic err_flag, uv_flag;
  logic [15:0] turns_w, filt_w, fine_w, cross_w, key_w;
  logic [7:0] code;
  logic [11:0] tmax, tmin;

  function automatic logic [7:0] key_code(input logic [2:0] s);
    case (s)
      3'h0: key_code = atr_pkg::KEY_C0;
      3'h1: key_code = atr_pkg::KEY_C1;
      3'h2: key_code = atr_pkg::KEY_C2;
      3'h3: key_code = atr_pkg::KEY_C3;
      default: key_code = atr_pkg::KEY_C4;
    endcase
  endfunction : key_code

  // odd parity over a 15-bit payload
  function automatic logic odd_par(input logic [14:0] d);
    odd_par = ~(^d);
  endfunction : odd_par

  always_comb
  begin
    err_flag = ANY_FAULT;
    uv_flag = (UV_ANALOG & ~MASK_UVA) | (UV_DIGITAL & ~MASK_UVD);
    turns_w = {atr_pkg::TURNS_ID, 1'b0, st_ff.turns};
    turns_w[atr_pkg::PAR_POS] = odd_par({turns_w[15:13], turns_w[11:0]});
    filt_w = {1'b0, err_flag, uv_flag, 1'b0, FILT_ANGLE};
    filt_w[atr_pkg::PAR_POS] = odd_par({err_flag, uv_flag, FILT_ANGLE});
    cross_w = {1'b0, err_flag, uv_flag, 1'b0, CROSS_ANGLE};
    cross_w[atr_pkg::PAR_POS] = odd_par({err_flag, uv_flag, CROSS_ANGLE});
    fine_w = {1'b0, FINE_ANGLE};
    key_w = 16'h0000;
    key_w[atr_pkg::UNL_POS] = st_ff.unlocked;
  end

  always_comb
  begin
    nxt_st = st_ff;
    code = WDATA[atr_pkg::CODE_LSB +: 8];
    tmax = STEP_45 ? atr_pkg::TURNS_MAX_45 : atr_pkg::TURNS_MAX_180;
    tmin = STEP_45 ? atr_pkg::TURNS_MIN_45 : atr_pkg::TURNS_MIN_180;
    // saturate at span ends; going past flags overflow
    if (TURNS_RESET)
    begin
      nxt_st.turns = atr_pkg::TURNS_RST;
      nxt_st.overflow = 1'b0;
    end
    else if (TURN_UP && !TURN_DN)
    begin
      if (st_ff.turns == tmax)
        nxt_st.overflow = 1'b1;
      else
        nxt_st.turns = st_ff.turns + 12'h001;
    end
    else if (TURN_DN && !TURN_UP)
    begin
      if (st_ff.turns == tmin)
        nxt_st.overflow = 1'b1;
      else
        nxt_st.turns = st_ff.turns - 12'h001;
    end
    if (WR_EN && ADDR == atr_pkg::ADDR_KEY)
    begin
      if (code == key_code(st_ff.step))
      begin
        if (st_ff.step == 3'(atr_pkg::KEY_STEPS - 1))
        begin
          nxt_st.unlocked = 1'b1;
          nxt_st.step = atr_pkg::STEP_RST;
        end
        else
          nxt_st.step = st_ff.step + 3'h1;
      end
      else
      begin
        // a stray code relocks, so half-entered keys never linger
        nxt_st.step = (code == atr_pkg::KEY_C0) ? 3'h1 : atr_pkg::STEP_RST;
        nxt_st.unlocked = 1'b0;
      end
    end
    nxt_st.rdata = 16'h0000;
    if (RD_EN)
    begin
      case (ADDR)
        atr_pkg::ADDR_TURNS: nxt_st.rdata = turns_w;
        atr_pkg::ADDR_FILT: nxt_st.rdata = filt_w;
        atr_pkg::ADDR_FINE: nxt_st.rdata = fine_w;
        atr_pkg::ADDR_CROSS: nxt_st.rdata = cross_w;
        atr_pkg::ADDR_KEY: nxt_st.rdata = key_w;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
    else
      nxt_st.rdata = st_ff.rdata;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      st_ff.turns <= atr_pkg::TURNS_RST;
      st_ff.overflow <= 1'b0;
      st_ff.step <= atr_pkg::STEP_RST;
      st_ff.unlocked <= 1'b0;
      st_ff.rdata <= 16'h0000;
    end
    else
      st_ff <= nxt_st;
  end

  assign RDATA = st_ff.rdata;
  assign PROT_GRANT = PROT_REQ & st_ff.unlocked;
  assign PROT_REFUSE = PROT_REQ & ~st_ff.unlocked;
  assign UNLOCKED = st_ff.unlocked;
  assign OVERFLOW_WARN = st_ff.overflow;

  property p_turns_id;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_TURNS |=> RDATA[15:13] == 3'h6 && ^RDATA;
  endproperty
  a_turns_id: assert property (p_turns_id) else $error("turns word id or parity bad");

  property p_filt_par;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_FILT |=> ^RDATA && !RDATA[15];
  endproperty
  a_filt_par: assert property (p_filt_par) else $error("filtered word parity bad");

  property p_cross;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_CROSS |=> ^RDATA && RDATA[11:0] == $past(CROSS_ANGLE);
  endproperty
  a_cross: assert property (p_cross) else $error("crossing word bad");

  property p_fine;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_FINE |=> RDATA == {1'b0, $past(FINE_ANGLE)};
  endproperty
  a_fine: assert property (p_fine) else $error("fine word bad");

  property p_key_read;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_KEY |=> RDATA[15:1] == 15'h0000 && RDATA[0] == $past(UNLOCKED);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key readback bad");

  property p_bad_code;
    @(posedge CLK_SYS) disable iff (!RESETN)
      WR_EN && ADDR == atr_pkg::ADDR_KEY && WDATA[15:8] != key_code(st_ff.step) |=> !UNLOCKED;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("wrong code left unlocked");

  property p_refuse;
    @(posedge CLK_SYS) disable iff (!RESETN)
      PROT_REQ |-> PROT_GRANT == UNLOCKED && PROT_REFUSE == !UNLOCKED;
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected access gate bad");

  property p_ovf_hold;
    @(posedge CLK_SYS) disable iff (!RESETN)
      OVERFLOW_WARN && !TURNS_RESET |=> OVERFLOW_WARN;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow warning dropped");

  property p_span;
    @(posedge CLK_SYS) disable iff (!RESETN)
      !STEP_45 && $past(!STEP_45) |-> $signed(st_ff.turns) <= 511 && $signed(st_ff.turns) >= -512;
  endproperty
  a_span: assert property (p_span) else $error("turn count out of span");

  property p_filt_ef;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_FILT |=> RDATA[14] == $past(ANY_FAULT);
  endproperty
  a_filt_ef: assert property (p_filt_ef) else $error("filtered error flag bad");

  property p_filt_uv;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_FILT |=> RDATA[13] == (($past(UV_ANALOG) && !$past(MASK_UVA))
        || ($past(UV_DIGITAL) && !$past(MASK_UVD)));
  endproperty
  a_filt_uv: assert property (p_filt_uv) else $error("filtered undervoltage flag bad");

  property p_filt_ang;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_FILT |=> RDATA[11:0] == $past(FILT_ANGLE);
  endproperty
  a_filt_ang: assert property (p_filt_ang) else $error("filtered angle field bad");

  property p_cross_ef;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_CROSS |=> RDATA[14] == $past(ANY_FAULT) && !RDATA[15];
  endproperty
  a_cross_ef: assert property (p_cross_ef) else $error("crossing error flag bad");

  property p_fine_top;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_FINE |=> !RDATA[15];
  endproperty
  a_fine_top: assert property (p_fine_top) else $error("fine word top bit set");

  property p_turns_val;
    @(posedge CLK_SYS) disable iff (!RESETN)
      RD_EN && ADDR == atr_pkg::ADDR_TURNS |=> RDATA[11:0] == $past(st_ff.turns);
  endproperty
  a_turns_val: assert property (p_turns_val) else $error("turns field bad");

  property p_up_step;
    @(posedge CLK_SYS) disable iff (!RESETN)
      TURN_UP && !TURN_DN && !TURNS_RESET && st_ff.turns != tmax
        |=> st_ff.turns == $past(st_ff.turns) + 12'h001;
  endproperty
  a_up_step: assert property (p_up_step) else $error("count up step bad");

  property p_dn_step;
    @(posedge CLK_SYS) disable iff (!RESETN)
      TURN_DN && !TURN_UP && !TURNS_RESET && st_ff.turns != tmin
        |=> st_ff.turns == $past(st_ff.turns) - 12'h001;
  endproperty
  a_dn_step: assert property (p_dn_step) else $error("count down step bad");

  property p_trst;
    @(posedge CLK_SYS) disable iff (!RESETN)
      TURNS_RESET |=> st_ff.turns == 12'h000 && !OVERFLOW_WARN;
  endproperty
  a_trst: assert property (p_trst) else $error("turns reset not applied");

  property p_ovf_set;
    @(posedge CLK_SYS) disable iff (!RESETN)
      !TURNS_RESET && ((TURN_UP && !TURN_DN && st_ff.turns == tmax)
        || (TURN_DN && !TURN_UP && st_ff.turns == tmin)) |=> OVERFLOW_WARN;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow warning not set");

  property p_unlock;
    @(posedge CLK_SYS) disable iff (!RESETN)
      WR_EN && ADDR == atr_pkg::ADDR_KEY && st_ff.step == 3'h4
        && WDATA[15:8] == atr_pkg::KEY_C4 |=> UNLOCKED;
  endproperty
  a_unlock: assert property (p_unlock) else $error("final code did not unlock");

  property p_step_adv;
    @(posedge CLK_SYS) disable iff (!RESETN)
      WR_EN && ADDR == atr_pkg::ADDR_KEY && WDATA[15:8] == key_code(st_ff.step)
        && st_ff.step != 3'h4 |=> st_ff.step == $past(st_ff.step) + 3'h1;
  endproperty
  a_step_adv: assert property (p_step_adv) else $error("key step did not advance");

  property p_no_spur;
    @(posedge CLK_SYS) disable iff (!RESETN)
      !UNLOCKED && !(WR_EN && ADDR == atr_pkg::ADDR_KEY) |=> !UNLOCKED;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("unlocked without key write");

  property p_step_range;
    @(posedge CLK_SYS) disable iff (!RESETN)
      st_ff.step <= 3'h4;
  endproperty
  a_step_range: assert property (p_step_range) else $error("key step out of range");

  property p_grant_lock;
    @(posedge CLK_SYS) disable iff (!RESETN)
      PROT_GRANT |-> UNLOCKED && !PROT_REFUSE;
  endproperty
  a_grant_lock: assert property (p_grant_lock) else $error("grant while locked");
endmodule : atr_regs

/* File: test/atr_host.sv */
`timescale 1ns/100ps
// host side of the register port; strobes are one-cycle pulses
module atr_host (
  input wire logic CLK_SYS,
  output logic [7:0] ADDR,
  output logic RD_EN,
  output logic WR_EN,
  output logic [15:0] WDATA,
  input wire logic [15:0] RDATA
);
  initial
  begin
    ADDR = 8'h00;
    RD_EN = 1'b0;
    WR_EN = 1'b0;
    WDATA = 16'h0000;
  end

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CLK_SYS);
    RD_EN <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  // data is inverted once released so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR_EN <= 1'b1;
    @(posedge CLK_SYS);
    WR_EN <= 1'b0;
    WDATA <= ~d;
  endtask : wr

  task automatic unlock();
    logic [7:0] c[5] = '{8'h00, 8'h27, 8'h81, 8'h1f, 8'h77};
    foreach (c[i]) wr(8'h3c, {c[i], 8'h00});
    #1;
  endtask : unlock
endmodule : atr_host

/* File: test/atr_regs_tb.sv */
`timescale 1ns/100ps
module atr_regs_tb;
  logic clk, rst_n, up, dn, trst, s45, flt, analog_undervoltage, digital_undervoltage, mua, mud, preq;
  logic [11:0] fa, ca;
  logic [14:0] fi;
  logic [7:0] addr;
  logic rde, wre, grant, refuse, unl, ovf, uv;
  logic [15:0] wd, rdat, d;
  logic [31:0] r = 32'h691e;
  int fails = 0;
  int comparisons = 0;

  atr_host i_host (.CLK_SYS(clk), .ADDR(addr), .RD_EN(rde), .WR_EN(wre), .WDATA(wd), .RDATA(rdat));
  atr_regs i_dut (.CLK_SYS(clk), .RESETN(rst_n), .ADDR(addr), .RD_EN(rde), .WR_EN(wre),
    .WDATA(wd), .RDATA(rdat), .TURN_UP(up), .TURN_DN(dn), .TURNS_RESET(trst), .STEP_45(s45),
    .FILT_ANGLE(fa), .FINE_ANGLE(fi), .CROSS_ANGLE(ca), .ANY_FAULT(flt), .UV_ANALOG(analog_undervoltage),
    .UV_DIGITAL(digital_undervoltage), .MASK_UVA(mua), .MASK_UVD(mud), .PROT_REQ(preq), .PROT_GRANT(grant),
    .PROT_REFUSE(refuse), .UNLOCKED(unl), .OVERFLOW_WARN(ovf));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // fills bit 12 so the word has odd ones
  function automatic logic [15:0] odd(input logic [15:0] w);
    odd = w;
    odd[12] = ~^w;
  endfunction : odd

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic pulse(input logic u, input int n);
    repeat (n)
    begin
      @(posedge clk);
      up <= u;
      dn <= !u;
      @(posedge clk);
      up <= 1'b0;
      dn <= 1'b0;
    end
    #1;
  endtask : pulse

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end

  initial
  begin
    {rst_n, up, dn, trst, s45, flt, analog_undervoltage, digital_undervoltage, mua, mud, preq, fa, ca, fi} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8)
    begin
      @(posedge clk);
      r = lfsr(r);
      {flt, analog_undervoltage, digital_undervoltage, mua, mud, fi} <= r[31:12];
      {fa, ca} <= {r[11:0], r[23:12]};
      @(posedge clk);
      uv = (analog_undervoltage & !mua) | (digital_undervoltage & !mud);
      i_host.rd(8'h30, d);
      chk("filtered", d, odd({1'b0, flt, uv, 1'b0, fa}));
      i_host.rd(8'h32, d);
      chk("fine", d, {1'b0, fi});
      i_host.rd(8'h34, d);
      chk("crossing", d, odd({1'b0, flt, uv, 1'b0, ca}));
    end
    $display("angle words done");
    pulse(1'b1, 511);
    chk("no warn", {15'h0000, ovf}, 16'h0000);
    pulse(1'b1, 1);
    i_host.rd(8'h2c, d);
    chk("turns max", d, odd(16'hc1ff));
    chk("warn", {15'h0000, ovf}, 16'h0001);
    @(posedge clk);
    trst <= 1'b1;
    s45 <= 1'b1;
    @(posedge clk);
    trst <= 1'b0;
    pulse(1'b0, 3);
    i_host.rd(8'h2c, d);
    chk("turns neg", d, odd(16'hcffd));
    chk("warn clr", {15'h0000, ovf}, 16'h0000);
    pulse(1'b0, 2045);
    i_host.rd(8'h2c, d);
    chk("turns min 45", d, odd(16'hc800));
    pulse(1'b0, 1);
    chk("warn 45", {15'h0000, ovf}, 16'h0001);
    $display("turns done");
    preq <= 1'b1;
    i_host.rd(8'h3c, d);
    chk("locked", {d, refuse, grant}, 18'h00002);
    i_host.unlock();
    i_host.rd(8'h3c, d);
    chk("unlocked", {d, refuse, grant}, 18'h00005);
    i_host.wr(8'h3c, 16'h2700);
    i_host.rd(8'h3c, d);
    chk("bad code", {d, refuse}, 17'h00001);
    i_host.rd(8'h10, d);
    chk("unmapped", d, 16'h0000);
    $display("key done");
    end_of_test();
  end
endmodule : atr_regs_tb
